// ==== logic/pcrp_pkg.sv ====
package pcrp_pkg;

    // ------------------------------------------------------------
    // access port geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          LEN_W           = 13;

    // ------------------------------------------------------------
    // register byte offsets (dword holding each register, except port caps)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_PORT_CTRL5  = 12'h068;
    localparam logic [11:0] OFF_CAP_LIST    = 12'h06C;
    localparam logic [11:0] OFF_PORT_CAPS   = 12'h06E;
    localparam logic [11:0] OFF_DEV_CAPS    = 12'h070;
    localparam logic [11:0] OFF_DEV_CTRL    = 12'h074;

    // ------------------------------------------------------------
    // port control five fields
    // ------------------------------------------------------------
    localparam int          BIT_INBAND_DIS  = 1;
    localparam int          BIT_L1HANG_DIS  = 0;

    // ------------------------------------------------------------
    // capability list header fields
    // ------------------------------------------------------------
    localparam logic [7:0]  CAP_ID_VALUE    = 8'h10;
    localparam logic [7:0]  NEXT_PTR_PORT0  = 8'h00;
    localparam logic [7:0]  NEXT_PTR_OTHER  = 8'hF0;

    // ------------------------------------------------------------
    // port capabilities fields
    // ------------------------------------------------------------
    localparam int          IMN_LSB         = 9;
    localparam int          SLOT_IMPL_BIT   = 8;
    localparam int          PORT_TYPE_LSB   = 4;
    localparam logic [4:0]  IMN_RESET       = 5'h00;
    localparam logic [3:0]  PORT_TYPE_ROOT  = 4'h4;
    localparam logic [3:0]  CAP_VERSION     = 4'h1;

    // ------------------------------------------------------------
    // device capabilities fields
    // ------------------------------------------------------------
    localparam int          PWR_SCALE_LSB   = 26;
    localparam int          PWR_VALUE_LSB   = 18;
    localparam int          ROLE_ERROR_REPORTING_CAP_BIT        = 15;
    localparam int          PWR_IND_BIT     = 14;
    localparam int          ATT_IND_BIT     = 13;
    localparam int          ATT_BTN_BIT     = 12;
    localparam int          EP_L1_LAT_LSB   = 9;
    localparam int          EP_L0S_LAT_LSB  = 6;
    localparam int          EXT_TAG_BIT     = 5;
    localparam int          PHANTOM_LSB     = 3;
    localparam logic [1:0]  PWR_SCALE_VAL   = 2'h0;
    localparam logic [7:0]  PWR_VALUE_VAL   = 8'h00;
    localparam logic [2:0]  EP_LAT_MAX      = 3'h7;
    localparam logic [1:0]  PHANTOM_VAL     = 2'h0;
    localparam logic [2:0]  MAX_PAYLOAD_SUP = 3'h1;

    // ------------------------------------------------------------
    // device control fields
    // ------------------------------------------------------------
    localparam int          MAX_READ_REQUEST_SIZE_LSB        = 12;
    localparam int          NO_SNOOP_BIT    = 11;
    localparam int          AUX_PWR_BIT     = 10;
    localparam int          MPS_LSB         = 5;
    localparam logic [2:0]  MAX_READ_REQUEST_SIZE_RESET      = 3'h0;
    localparam logic        NO_SNOOP_RESET  = 1'b1;
    localparam logic        AUX_PWR_RESET   = 1'b0;
    localparam logic [2:0]  MPS_RESET       = 3'h0;
    localparam logic [3:0]  ERR_EN_RESET    = 4'h0;

    // ------------------------------------------------------------
    // transaction limits in bytes
    // ------------------------------------------------------------
    localparam logic [12:0] PAYLOAD_LIMIT   = 13'h0100;
    localparam logic [12:0] READ_LIMIT      = 13'h0040;
    localparam logic [12:0] MPS_BASE_BYTES  = 13'h0080;

endpackage

// ==== logic/pcrp_tlp_guard.sv ====
`timescale 1ns/10ps
module pcrp_tlp_guard
    import pcrp_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       tlpValid,
    input  wire logic [pcrp_pkg::LEN_W-1:0] tlpPayloadLen,
    input  wire logic [2:0]                 mpsCode,
    input  wire logic                       readReqValid,
    input  wire logic [pcrp_pkg::LEN_W-1:0] readReqLen,
    output logic                            payloadError,
    output logic                            readOutValid,
    output logic [pcrp_pkg::LEN_W-1:0]      readOutLen
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [LEN_W-1:0] mpsBytes(input logic [2:0] code);
        mpsBytes = (code == 3'h0) ? MPS_BASE_BYTES : PAYLOAD_LIMIT;
    endfunction

    function automatic logic [LEN_W-1:0] clampLen(input logic [LEN_W-1:0] len,
                                                  input logic [LEN_W-1:0] lim);
        clampLen = (len > lim) ? lim : len;
    endfunction

    // ------------------------------------------------------------
    // payload check
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            payloadError <= 1'b0;
        end else begin
            payloadError <= tlpValid && ((tlpPayloadLen > PAYLOAD_LIMIT) ||
                            (tlpPayloadLen > mpsBytes(mpsCode)) ||
                            (mpsCode > MAX_PAYLOAD_SUP));
        end
    end

    // ------------------------------------------------------------
    // outbound read size limit
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            readOutValid <= 1'b0;
            readOutLen   <= '0;
        end else begin
            readOutValid <= readReqValid;
            readOutLen   <= clampLen(readReqLen, READ_LIMIT);
        end
    end

endmodule

// ==== logic/pcrp_root_port_regs.sv ====
`timescale 1ns/10ps
// Behaviour
// - bit 1 of port control five set suppresses in-band presence detection
// - bit 0 at zero keeps the l1 hang guard active during card l1 entry
// - capability identifier reads fixed 10h, writes ignored
// - next pointer reads 00h on port 0, F0h on other ports
// - interrupt message index is read-only, resets 00h, holds msi offset
// - interrupt message index reloads whenever enabled msi count changes
// - slot implemented writable once on ports 7-1, read-only zero on port 0
// - port type field reads 0100 on every port
// - capability version reads 0001
// - slot power scale and value hardwired to zero
// - role based error reporting bit reads one
// - indicator and button present bits read zero
// - endpoint l1 latency reads 111
// - endpoint l0s latency reads 111
// - extended tag supported reads zero, five bit tags only
// - phantom functions supported reads zero
// - max payload supported reads 001, payloads over 256 bytes flagged
// - read request size resets 000, outbound reads limited to 64 bytes
// - no snoop enable resets one, received no snoop passes untouched
// - aux power enable is sticky read/write, reset zero
module pcrp_root_port_regs
    import pcrp_pkg::*;
#(
    parameter int unsigned PORT_NUM = 1
)
(
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        portRst,
    input  wire logic                        cfgWrEn,
    input  wire logic                        cfgRdEn,
    input  wire logic [pcrp_pkg::ADDR_W-1:0] cfgAddr,
    input  wire logic [3:0]                  cfgByteEn,
    input  wire logic [pcrp_pkg::DATA_W-1:0] cfgWrData,
    output logic      [pcrp_pkg::DATA_W-1:0] cfgRdData,
    output logic                             cfgRdValid,
    input  wire logic                        ltssmInbandPresence,
    input  wire logic                        aspmL1Active,
    input  wire logic [2:0]                  msiEnabledCount,
    input  wire logic [4:0]                  msiMessageOffset,
    input  wire logic                        tlpValid,
    input  wire logic [pcrp_pkg::LEN_W-1:0]  tlpPayloadLen,
    input  wire logic                        readReqValid,
    input  wire logic [pcrp_pkg::LEN_W-1:0]  readReqLen,
    input  wire logic                        rxTlpValid,
    input  wire logic                        rxNoSnoop,
    output logic                             inbandPresenceDisable,
    output logic                             l1HangWorkaroundDisable,
    output logic                             presenceDetected,
    output logic                             l1HangGuard,
    output logic                             slotImplemented,
    output logic                             noSnoopEnable,
    output logic                             auxPowerEnable,
    output logic      [2:0]                  maxReadRequestSize,
    output logic      [2:0]                  maxPayloadSize,
    output logic                             payloadError,
    output logic                             readOutValid,
    output logic      [pcrp_pkg::LEN_W-1:0]  readOutLen,
    output logic                             fwdTlpValid,
    output logic                             fwdNoSnoop
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] mergeByte(input logic [7:0] oldVal,
                                             input logic [7:0] newVal,
                                             input logic [7:0] wrMask,
                                             input logic       lane);
        mergeByte = lane ? ((oldVal & ~wrMask) | (newVal & wrMask)) : oldVal;
    endfunction

    function automatic logic hitDword(input logic [ADDR_W-1:0] addr,
                                      input logic [11:0]       off);
        hitDword = (addr[ADDR_W-1:2] == off[11:2]);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0]        portCtrl_q;
    logic [4:0]        imn_q;
    logic [2:0]        msiCountSeen_q;
    logic              slotImpl_q;
    logic              slotLocked_q;
    logic [2:0]        max_read_request_size_q;
    logic              noSnoop_q;
    logic              auxPwr_q;
    logic [2:0]        mps_q;
    logic [3:0]        errEn_q;
    logic [7:0]        nextPtr;
    logic [15:0]       capList;
    logic [15:0]       portCaps;
    logic [31:0]       devCaps;
    logic [15:0]       devCtrl;
    logic [31:0]       rdMux;
    logic              wrCtrl5;
    logic              wrCapDw;
    logic              wrDevCtrl;
    logic [7:0]        ctrl5Byte;
    logic [7:0]        devCtrlLo;
    logic [7:0]        devCtrlHi;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    assign wrCtrl5   = cfgWrEn && hitDword(cfgAddr, OFF_PORT_CTRL5);
    assign wrCapDw   = cfgWrEn && hitDword(cfgAddr, OFF_CAP_LIST);
    assign wrDevCtrl = cfgWrEn && hitDword(cfgAddr, OFF_DEV_CTRL);

    // only implemented bits take writes
    assign ctrl5Byte = mergeByte({6'h00, portCtrl_q}, cfgWrData[7:0], 8'h03,
                                 cfgByteEn[0]);
    assign devCtrlLo = mergeByte({mps_q, 1'b0, errEn_q}, cfgWrData[7:0], 8'hEF,
                                 cfgByteEn[0]);
    assign devCtrlHi = mergeByte({1'b0, max_read_request_size_q, noSnoop_q, auxPwr_q, 2'h0},
                                 cfgWrData[15:8], 8'h7C, cfgByteEn[1]);

    // ------------------------------------------------------------
    // port control five
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            portCtrl_q <= 2'h0;
        end else if (portRst) begin
            portCtrl_q <= 2'h0;
        end else if (wrCtrl5) begin
            portCtrl_q <= ctrl5Byte[1:0];
        end
    end

    // ------------------------------------------------------------
    // presence detect and l1 hang guard
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            presenceDetected <= 1'b0;
        end else begin
            presenceDetected <= ltssmInbandPresence &&
                                !portCtrl_q[BIT_INBAND_DIS];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            l1HangGuard <= 1'b0;
        end else begin
            l1HangGuard <= aspmL1Active && !portCtrl_q[BIT_L1HANG_DIS];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            inbandPresenceDisable   <= 1'b0;
            l1HangWorkaroundDisable <= 1'b0;
        end else begin
            inbandPresenceDisable   <= portCtrl_q[BIT_INBAND_DIS];
            l1HangWorkaroundDisable <= portCtrl_q[BIT_L1HANG_DIS];
        end
    end

    // ------------------------------------------------------------
    // interrupt message index
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            imn_q          <= IMN_RESET;
            msiCountSeen_q <= 3'h0;
        end else if (portRst) begin
            imn_q          <= IMN_RESET;
            msiCountSeen_q <= 3'h0;
        end else begin
            msiCountSeen_q <= msiEnabledCount;
            if (msiEnabledCount != msiCountSeen_q) begin
                imn_q <= msiMessageOffset;
            end
        end
    end

    // ------------------------------------------------------------
    // slot implemented, write once
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slotImpl_q   <= 1'b0;
            slotLocked_q <= 1'b0;
        end else if (PORT_NUM == 0) begin
            slotImpl_q   <= 1'b0;
            slotLocked_q <= 1'b1;
        end else if (wrCapDw && cfgByteEn[3] && !slotLocked_q) begin
            slotImpl_q   <= cfgWrData[16 + SLOT_IMPL_BIT];
            slotLocked_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slotImplemented <= 1'b0;
        end else begin
            slotImplemented <= slotImpl_q;
        end
    end

    // ------------------------------------------------------------
    // device control, non-sticky fields
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            max_read_request_size_q    <= MAX_READ_REQUEST_SIZE_RESET;
            noSnoop_q <= NO_SNOOP_RESET;
            mps_q     <= MPS_RESET;
            errEn_q   <= ERR_EN_RESET;
        end else if (portRst) begin
            max_read_request_size_q    <= MAX_READ_REQUEST_SIZE_RESET;
            noSnoop_q <= NO_SNOOP_RESET;
            mps_q     <= MPS_RESET;
            errEn_q   <= ERR_EN_RESET;
        end else if (wrDevCtrl) begin
            max_read_request_size_q    <= devCtrlHi[6:4];
            noSnoop_q <= devCtrlHi[3];
            mps_q     <= devCtrlLo[7:5];
            errEn_q   <= devCtrlLo[3:0];
        end
    end

    // ------------------------------------------------------------
    // device control, sticky aux power enable
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            auxPwr_q <= AUX_PWR_RESET;
        end else if (wrDevCtrl) begin
            auxPwr_q <= devCtrlHi[2];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            noSnoopEnable      <= NO_SNOOP_RESET;
            auxPowerEnable     <= AUX_PWR_RESET;
            maxReadRequestSize <= MAX_READ_REQUEST_SIZE_RESET;
            maxPayloadSize     <= MPS_RESET;
        end else begin
            noSnoopEnable      <= noSnoop_q;
            auxPowerEnable     <= auxPwr_q;
            maxReadRequestSize <= max_read_request_size_q;
            maxPayloadSize     <= mps_q;
        end
    end

    // ------------------------------------------------------------
    // received no snoop attribute passes unchanged
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fwdTlpValid <= 1'b0;
            fwdNoSnoop  <= 1'b0;
        end else begin
            fwdTlpValid <= rxTlpValid;
            fwdNoSnoop  <= rxNoSnoop;
        end
    end

    // ------------------------------------------------------------
    // payload and read size guard
    // ------------------------------------------------------------
    pcrp_tlp_guard uGuard (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .tlpValid      (tlpValid),
        .tlpPayloadLen (tlpPayloadLen),
        .mpsCode       (mps_q),
        .readReqValid  (readReqValid),
        .readReqLen    (readReqLen),
        .payloadError  (payloadError),
        .readOutValid  (readOutValid),
        .readOutLen    (readOutLen)
    );

    // ------------------------------------------------------------
    // read-back images
    // ------------------------------------------------------------
    assign nextPtr  = (PORT_NUM == 0) ? NEXT_PTR_PORT0 : NEXT_PTR_OTHER;
    assign capList  = {nextPtr, CAP_ID_VALUE};

    always_comb begin
        portCaps                                 = 16'h0000;
        portCaps[IMN_LSB +: 5]                   = imn_q;
        portCaps[SLOT_IMPL_BIT]                  = slotImpl_q;
        portCaps[PORT_TYPE_LSB +: 4]             = PORT_TYPE_ROOT;
        portCaps[3:0]                            = CAP_VERSION;
    end

    always_comb begin
        devCaps                                  = 32'h00000000;
        devCaps[PWR_SCALE_LSB +: 2]              = PWR_SCALE_VAL;
        devCaps[PWR_VALUE_LSB +: 8]              = PWR_VALUE_VAL;
        devCaps[ROLE_ERROR_REPORTING_CAP_BIT]                        = 1'b1;
        devCaps[PWR_IND_BIT]                     = 1'b0;
        devCaps[ATT_IND_BIT]                     = 1'b0;
        devCaps[ATT_BTN_BIT]                     = 1'b0;
        devCaps[EP_L1_LAT_LSB +: 3]              = EP_LAT_MAX;
        devCaps[EP_L0S_LAT_LSB +: 3]             = EP_LAT_MAX;
        devCaps[EXT_TAG_BIT]                     = 1'b0;
        devCaps[PHANTOM_LSB +: 2]                = PHANTOM_VAL;
        devCaps[2:0]                             = MAX_PAYLOAD_SUP;
    end

    always_comb begin
        devCtrl                                  = 16'h0000;
        devCtrl[MAX_READ_REQUEST_SIZE_LSB +: 3]                   = max_read_request_size_q;
        devCtrl[NO_SNOOP_BIT]                    = noSnoop_q;
        devCtrl[AUX_PWR_BIT]                     = auxPwr_q;
        devCtrl[MPS_LSB +: 3]                    = mps_q;
        devCtrl[3:0]                             = errEn_q;
    end

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        rdMux = 32'h00000000;
        if (hitDword(cfgAddr, OFF_PORT_CTRL5)) begin
            rdMux = {30'h0, portCtrl_q};
        end else if (hitDword(cfgAddr, OFF_CAP_LIST)) begin
            rdMux = {portCaps, capList};
        end else if (hitDword(cfgAddr, OFF_DEV_CAPS)) begin
            rdMux = devCaps;
        end else if (hitDword(cfgAddr, OFF_DEV_CTRL)) begin
            rdMux = {16'h0000, devCtrl};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgRdData  <= 32'h00000000;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdValid <= cfgRdEn;
            if (cfgRdEn) begin
                cfgRdData <= rdMux;
            end
        end
    end

endmodule

// ==== verification/pcrp_checker.sv ====
`timescale 1ns/10ps
module pcrp_checker
    import pcrp_pkg::*;
#(parameter int unsigned PORT_NUM = 1)
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        cfgRdEn,
    input wire logic [11:0] cfgAddr,
    input wire logic [31:0] cfgRdData,
    input wire logic        cfgRdValid,
    input wire logic        ltssmInbandPresence,
    input wire logic        aspmL1Active,
    input wire logic        tlpValid,
    input wire logic [12:0] tlpPayloadLen,
    input wire logic        readReqValid,
    input wire logic [12:0] readReqLen,
    input wire logic        rxTlpValid,
    input wire logic        rxNoSnoop,
    input wire logic        inbandPresenceDisable,
    input wire logic        l1HangWorkaroundDisable,
    input wire logic        presenceDetected,
    input wire logic        l1HangGuard,
    input wire logic        payloadError,
    input wire logic        readOutValid,
    input wire logic [12:0] readOutLen,
    input wire logic        fwdTlpValid,
    input wire logic        fwdNoSnoop
);
    localparam logic [7:0] NP = (PORT_NUM == 0) ? 8'h00 : 8'hF0;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence rdCap; cfgRdEn && cfgAddr[11:2] == 10'h01B; endsequence
    sequence rdDev; cfgRdEn && cfgAddr[11:2] == 10'h01C; endsequence
    cap_header_a: assert property (rdCap |=>
        {cfgRdData[31:30], cfgRdData[23:0]} == {2'h0, 8'h41, NP, 8'h10}) else $error("bad header");
    dev_caps_a: assert property (rdDev |=> cfgRdData == 32'h0000_8FC1)
        else $error("bad device capabilities");
    read_pulse_a: assert property (cfgRdValid |-> $past(cfgRdEn))
        else $error("read valid without read");
    presence_gate_a: assert property (!$past(sys_rst) |->
        presenceDetected == ($past(ltssmInbandPresence) && !inbandPresenceDisable)) else $error("presence");
    l1_guard_a: assert property (!$past(sys_rst) |->
        l1HangGuard == ($past(aspmL1Active) && !l1HangWorkaroundDisable)) else $error("l1 guard");
    read_clamp_a: assert property (readReqValid |=> readOutValid && readOutLen ==
        (($past(readReqLen) > 13'h0040) ? 13'h0040 : $past(readReqLen))) else $error("read clamp");
    payload_err_a: assert property (tlpValid && tlpPayloadLen > 13'h0100 |=> payloadError)
        else $error("oversize payload not flagged");
    no_snoop_a: assert property (rxTlpValid |=> fwdTlpValid && fwdNoSnoop == $past(rxNoSnoop))
        else $error("no snoop altered");
endmodule
bind pcrp_root_port_regs pcrp_checker #(.PORT_NUM(PORT_NUM)) pcrp_checker_inst (
    .clk, .sys_rst, .cfgRdEn, .cfgAddr, .cfgRdData, .cfgRdValid, .ltssmInbandPresence,
    .aspmL1Active, .tlpValid, .tlpPayloadLen, .readReqValid, .readReqLen, .rxTlpValid,
    .rxNoSnoop, .inbandPresenceDisable, .l1HangWorkaroundDisable, .presenceDetected,
    .l1HangGuard, .payloadError, .readOutValid, .readOutLen, .fwdTlpValid, .fwdNoSnoop);

// ==== verification/pcrp_root_port_regs_tb.sv ====
`timescale 1ns/10ps
module pcrp_root_port_regs_tb;
    logic        clk, sys_rst, portRst, cfgWrEn, cfgRdEn, ltssmInbandPresence, aspmL1Active;
    logic        tlpValid, readReqValid, rxTlpValid, rxNoSnoop, cfgRdValid;
    logic [11:0] cfgAddr;
    logic [3:0]  cfgByteEn;
    logic [31:0] cfgWrData, cfgRdData, expQ[$];
    logic [2:0]  msiEnabledCount, maxReadRequestSize, maxPayloadSize;
    logic        slotImplemented, noSnoopEnable, auxPowerEnable, inbandPresenceDisable;
    logic        l1HangWorkaroundDisable;
    logic [10:0] statusVec;
    logic [4:0]  msiMessageOffset;
    logic [12:0] tlpPayloadLen, readReqLen;
    int          errorCnt, comparisons;
    pcrp_root_port_regs pcrp_root_port_regs_inst (.clk, .sys_rst, .portRst, .cfgWrEn, .cfgRdEn,
        .cfgAddr, .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid, .ltssmInbandPresence,
        .aspmL1Active, .msiEnabledCount, .msiMessageOffset, .tlpValid, .tlpPayloadLen,
        .readReqValid, .readReqLen, .rxTlpValid, .rxNoSnoop, .inbandPresenceDisable,
        .l1HangWorkaroundDisable, .presenceDetected(), .l1HangGuard(), .slotImplemented,
        .noSnoopEnable, .auxPowerEnable, .maxReadRequestSize, .maxPayloadSize,
        .payloadError(), .readOutValid(), .readOutLen(), .fwdTlpValid(), .fwdNoSnoop());
    assign statusVec = {slotImplemented, noSnoopEnable, auxPowerEnable, inbandPresenceDisable,
        l1HangWorkaroundDisable, maxReadRequestSize, maxPayloadSize};
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic tick; @(posedge clk); #1; endtask
    task automatic stopTest;
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------------------
    // register port driver and read monitor
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        {cfgAddr, cfgByteEn, cfgWrData, cfgWrEn} = {a, be, d, 1'h1};
        tick;
        cfgWrEn = 1'h0;
        tick;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expQ.push_back(e);
        {cfgAddr, cfgRdEn} = {a, 1'h1};
        tick;
        cfgRdEn = 1'h0;
        tick;
    endtask
    always @(posedge clk) if (cfgRdValid === 1'h1) chk(cfgRdData, expQ.pop_front());
    task automatic traffic;
        repeat (24) begin
            {ltssmInbandPresence, aspmL1Active, tlpValid, readReqValid, rxTlpValid, rxNoSnoop} = 6'($urandom);
            tlpPayloadLen = 13'($urandom_range(512));
            readReqLen = 13'($urandom_range(128));
            tick;
        end
        {tlpValid, readReqValid, rxTlpValid} = 3'h0;
    endtask
    initial begin
        #20000;
        errorCnt++;
        stopTest;
    end
    initial begin
        logic [31:0] d;
        {sys_rst, portRst, cfgWrEn, cfgRdEn, cfgAddr, cfgByteEn, cfgWrData} = {2'h2, 50'h0};
        {ltssmInbandPresence, aspmL1Active, msiEnabledCount, msiMessageOffset} = 10'h0;
        {tlpValid, tlpPayloadLen, readReqValid, readReqLen, rxTlpValid, rxNoSnoop} = 30'h0;
        void'($urandom(32'h51b7));
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'h0;
        rd(12'h068, 32'h0);
        rd(12'h06C, 32'h0041_F010);
        rd(12'h070, 32'h0000_8FC1);
        rd(12'h074, 32'h0000_0800);
        rd(12'h07C, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            wr(12'h068, 4'hF, d);
            rd(12'h068, d & 32'h3);
            wr(12'h074, 4'hF, d);
            rd(12'h074, d & 32'h7CEF);
            wr(12'h070, 4'hF, d);
        end
        rd(12'h070, 32'h0000_8FC1);
        wr(12'h06C, 4'hF, 32'hFFFF_FFFF);
        rd(12'h06C, 32'h0141_F010);
        wr(12'h06C, 4'h8, 32'h0);
        rd(12'h06E, 32'h0141_F010);
        $display("test writes done");
        {msiMessageOffset, msiEnabledCount} = {5'h15, 3'h3};
        repeat (3) tick;
        rd(12'h06C, 32'h2B41_F010);
        {msiMessageOffset, msiEnabledCount} = {5'h0A, 3'h1};
        repeat (3) tick;
        rd(12'h06C, 32'h1541_F010);
        $display("test message index done");
        wr(12'h074, 4'hF, 32'h0000_3420);
        wr(12'h068, 4'hF, 32'h3);
        chk(32'(statusVec), 32'h0000_05D9);
        traffic;
        portRst = 1'h1;
        tick;
        portRst = 1'h0;
        rd(12'h074, 32'h0000_0C00);
        rd(12'h068, 32'h0);
        chk(32'(statusVec), 32'h0000_0700);
        traffic;
        $display("test port reset and traffic done");
        repeat (2) tick;
        if (expQ.size() != 0) errorCnt++;
        stopTest;
    end
endmodule
